// ===== design/bdma_cfg.svh
`ifndef BDMA_CFG_SVH
`define BDMA_CFG_SVH

// Fixed locations at the bottom of the data map.
`define BDMA_MAP_BASE     8'h00
`define BDMA_ADDR_IND_A   8'h00
`define BDMA_ADDR_PTR_A   8'h01
`define BDMA_ADDR_IND_B   8'h02
`define BDMA_ADDR_PTR_B   8'h03
`define BDMA_ADDR_BANK    8'h04
`define BDMA_ADDR_EXT_LO  8'h05

// General purpose window, the same in every bank.
`define BDMA_GP_BASE      8'h40
`define BDMA_GP_TOP       8'hFF
`define BDMA_NUM_BANKS    2

// Field position and reset values.
`define BDMA_BANK_BIT     0
`define BDMA_BANK_RST     1'b0
`define BDMA_PTR_RST      8'h00
`define BDMA_ZERO_BYTE    8'h00

`endif

// ===== design/bdma_pkg.sv
package bdma_pkg;

  typedef logic [7:0] bdma_byte_t;

  // Where an effective address lands after indirection.
  typedef enum logic [2:0] {
    BDMA_K_NONE,
    BDMA_K_PTR_A,
    BDMA_K_PTR_B,
    BDMA_K_BANK,
    BDMA_K_EXT,
    BDMA_K_GP
  } bdma_kind_t;

endpackage : bdma_pkg

// ===== design/bdma_ram.sv
`timescale 1ns/10ps
`default_nettype none

module bdma_ram #(
  parameter int DW    = 8,
  parameter int DEPTH = 384,
  parameter int AW    = 9
) (
  input  wire logic          clk,    // Core clock.
  input  wire logic          we,     // Write strobe.
  input  wire logic          re,     // Read strobe.
  input  wire logic [AW-1:0] addr,   // Word index.
  input  wire logic [DW-1:0] wdata,  // Write data.
  output logic      [DW-1:0] rdata   // Registered read data.
);

  // The array has no reset: its contents are undefined after power-up.
  logic [DW-1:0] mem [DEPTH];

  // Refused at elaboration: a depth beyond the address range would alias.
  if (DEPTH > (1 << AW)) begin
    $error("bdma_ram: DEPTH does not fit AW");
  end

  always_ff @(posedge clk) begin
    if (we) begin
      mem[addr] <= wdata;
    end
  end

  always_ff @(posedge clk) begin
    if (re) begin
      rdata <= mem[addr];
    end
  end

endmodule : bdma_ram

`default_nettype wire

// ===== design/bdma_core.sv
// Function
// - Each data memory byte is eight bits wide and keeps no value over power loss.
// - The data map starts at address 00H.
// - Every general purpose byte can be read and written without restriction.
// - Special function locations reach the same registers in every bank.
// - Accesses to an indirect port act on the byte whose address its pointer holds.
// - An indirect access that lands on an indirect port reads 00H and writes nothing.
// - Both pointers are ordinary readable and writable registers.
// - The first indirect port always reaches bank 0.
// - The second indirect port reaches the bank held in the bank selector.
// - Direct accesses always reach bank 0.
// - Bank selector bit 0 picks bank 0 or bank 1.
// - Any reset clears the bank selector except a watchdog reset in power-down.
// - Bank selector bits 7 to 1 are absent and read as zero.
`include "bdma_cfg.svh"
`timescale 1ns/10ps
`default_nettype none

module bdma_core
  import bdma_pkg::*;
#(
  parameter int GP_BASE = `BDMA_GP_BASE,
  parameter int GP_TOP  = `BDMA_GP_TOP,
  parameter int BANKS   = `BDMA_NUM_BANKS
) (
  input  wire logic       clk,           // Core clock, 100 MHz.
  input  wire logic       arst_n,        // Power-on reset, active low.
  input  wire logic       rst_evt,       // Pulse: a system reset occurred.
  input  wire logic       rst_wdt_pd,    // Level: that reset is a sleep WDT.
  input  wire logic       rd_en,         // Operand read strobe.
  input  wire logic       wr_en,         // Operand write strobe.
  input  wire logic [7:0] addr,          // Operand address.
  input  wire logic [7:0] wdata,         // Operand write data.
  output logic      [7:0] rdata,         // Read data, one cycle later.
  output logic            ext_sel,       // Peripheral register access.
  output logic            ext_we,        // Peripheral write strobe.
  output logic      [7:0] ext_addr,      // Peripheral register address.
  output logic      [7:0] ext_wdata,     // Peripheral write data.
  input  wire logic       ext_hit,       // Peripheral owns ext_addr.
  input  wire logic [7:0] ext_rdata      // Peripheral read data.
);

  localparam int GP_DEPTH  = GP_TOP - GP_BASE + 1;
  localparam int RAM_DEPTH = BANKS * GP_DEPTH;
  localparam int RAM_AW    = $clog2(RAM_DEPTH);

  // The bank arithmetic assumes two banks and a window above the ports.
  if (BANKS != 2 || GP_TOP > 255 || GP_BASE <= 5 || GP_TOP < GP_BASE) begin
    $error("bdma_core: unsupported map parameters");
  end

  logic [7:0]        ptr_a_val_reg;
  logic [7:0]        ptr_b_val_reg;
  logic              bank_sel_reg;
  logic              ind_a;
  logic              ind_b;
  logic [7:0]        eff_addr;
  logic              eff_bank;
  bdma_kind_t        kind;
  logic [RAM_AW-1:0] ram_addr;
  logic [7:0]        gp_off;
  logic [7:0]        ram_q;
  logic              from_ram_reg;
  logic [7:0]        loc_rdata_reg;
  logic [7:0]        loc_rdata_next;

  // Classify an effective address; the indirect ports own no storage.
  function automatic bdma_kind_t classify(input logic [7:0] a);
    if (a == `BDMA_ADDR_PTR_A) begin
      classify = BDMA_K_PTR_A;
    end else if (a == `BDMA_ADDR_PTR_B) begin
      classify = BDMA_K_PTR_B;
    end else if (a == `BDMA_ADDR_BANK) begin
      classify = BDMA_K_BANK;
    end else if (a >= `BDMA_ADDR_EXT_LO && a < 8'(GP_BASE)) begin
      classify = BDMA_K_EXT;
    end else if (a >= 8'(GP_BASE) && a <= 8'(GP_TOP)) begin
      classify = BDMA_K_GP;
    end else begin
      classify = BDMA_K_NONE;
    end
  endfunction : classify

  always_comb begin
    ind_a = (addr == `BDMA_ADDR_IND_A);
    ind_b = (addr == `BDMA_ADDR_IND_B);
    if (ind_a) begin
      eff_addr = ptr_a_val_reg;
    end else if (ind_b) begin
      eff_addr = ptr_b_val_reg;
    end else begin
      eff_addr = addr;
    end
    eff_bank = ind_b ? bank_sel_reg : 1'b0;
    kind = classify(eff_addr);
  end

  assign gp_off   = eff_addr - 8'(GP_BASE);
  assign ram_addr = eff_bank ? RAM_AW'(GP_DEPTH) + RAM_AW'(gp_off)
                             : RAM_AW'(gp_off);

  bdma_ram #(
    .DW    (8),
    .DEPTH (RAM_DEPTH),
    .AW    (RAM_AW)
  ) u_ram (
    .clk   (clk),
    .we    (wr_en && kind == BDMA_K_GP),
    .re    (rd_en && kind == BDMA_K_GP),
    .addr  (ram_addr),
    .wdata (wdata),
    .rdata (ram_q)
  );

  // Peripheral registers live outside; only the strobes are steered here.
  assign ext_sel   = (rd_en || wr_en) && kind == BDMA_K_EXT;
  assign ext_we    = wr_en && kind == BDMA_K_EXT;
  assign ext_addr  = eff_addr;
  assign ext_wdata = wdata;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ptr_a_val_reg <= `BDMA_PTR_RST;
    end else if (wr_en && kind == BDMA_K_PTR_A) begin
      ptr_a_val_reg <= wdata;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ptr_b_val_reg <= `BDMA_PTR_RST;
    end else if (wr_en && kind == BDMA_K_PTR_B) begin
      ptr_b_val_reg <= wdata;
    end
  end

  // A reset event beats a write in the same cycle, since the core restarts.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      bank_sel_reg <= `BDMA_BANK_RST;
    end else if (rst_evt) begin
      if (!rst_wdt_pd) begin
        bank_sel_reg <= `BDMA_BANK_RST;
      end
    end else if (wr_en && kind == BDMA_K_BANK) begin
      bank_sel_reg <= wdata[`BDMA_BANK_BIT];
    end
  end

  always_comb begin
    loc_rdata_next = `BDMA_ZERO_BYTE;
    unique case (kind)
      BDMA_K_PTR_A: loc_rdata_next = ptr_a_val_reg;
      BDMA_K_PTR_B: loc_rdata_next = ptr_b_val_reg;
      BDMA_K_BANK:  loc_rdata_next = {7'h00, bank_sel_reg};
      BDMA_K_EXT:   loc_rdata_next = ext_hit ? ext_rdata : `BDMA_ZERO_BYTE;
      BDMA_K_GP:    loc_rdata_next = `BDMA_ZERO_BYTE;
      BDMA_K_NONE:  loc_rdata_next = `BDMA_ZERO_BYTE;
    endcase
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      loc_rdata_reg <= `BDMA_ZERO_BYTE;
      from_ram_reg  <= 1'b0;
    end else if (rd_en) begin
      loc_rdata_reg <= loc_rdata_next;
      from_ram_reg  <= (kind == BDMA_K_GP);
    end
  end

  // Both sources are flip-flops; the RAM keeps its own output register.
  assign rdata = from_ram_reg ? ram_q : loc_rdata_reg;

  // Helper state for read-after-write checks.
  logic              hw_gp_wr_q;
  logic [RAM_AW-1:0] hw_wr_addr_q;
  logic [7:0]        hw_wr_data_q;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      hw_gp_wr_q   <= 1'b0;
      hw_wr_addr_q <= '0;
      hw_wr_data_q <= 8'h00;
    end else begin
      hw_gp_wr_q   <= wr_en && kind == BDMA_K_GP;
      hw_wr_addr_q <= ram_addr;
      hw_wr_data_q <= wdata;
    end
  end

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!arst_n);

  a_gp_readback: assert property (
    hw_gp_wr_q && rd_en && !wr_en && kind == BDMA_K_GP
    && ram_addr == hw_wr_addr_q |=> rdata == $past(hw_wr_data_q))
    else $error("general purpose byte did not read back");

  a_spec_bankfree: assert property (
    rd_en && ind_b && ptr_b_val_reg == `BDMA_ADDR_PTR_A
    |=> rdata == $past(ptr_a_val_reg))
    else $error("banked path changed special register");

  a_ind_redirect: assert property (
    wr_en && ind_a && ptr_a_val_reg == `BDMA_ADDR_PTR_B
    |=> ptr_b_val_reg == $past(wdata))
    else $error("indirect write missed pointer target");

  a_ind_self_zero: assert property (
    rd_en && (ind_a || ind_b)
    && (eff_addr == `BDMA_ADDR_IND_A || eff_addr == `BDMA_ADDR_IND_B)
    |=> rdata == 8'h00)
    else $error("indirect self read not zero");

  a_ptr_write: assert property (
    wr_en && addr == `BDMA_ADDR_PTR_A ##1 rd_en && addr == `BDMA_ADDR_PTR_A
    |=> rdata == $past(wdata, 2))
    else $error("pointer A did not hold written value");

  a_port_a_bank0: assert property (
    (rd_en || wr_en) && ind_a && kind == BDMA_K_GP
    |-> ram_addr < RAM_AW'(GP_DEPTH))
    else $error("port A left bank 0");

  a_port_b_bank: assert property (
    (rd_en || wr_en) && ind_b && kind == BDMA_K_GP
    |-> (ram_addr >= RAM_AW'(GP_DEPTH)) == bank_sel_reg)
    else $error("port B ignored bank selector");

  a_direct_bank0: assert property (
    (rd_en || wr_en) && !ind_a && !ind_b && kind == BDMA_K_GP
    |-> ram_addr < RAM_AW'(GP_DEPTH))
    else $error("direct access left bank 0");

  a_bank_write: assert property (
    wr_en && addr == `BDMA_ADDR_BANK && !rst_evt
    |=> bank_sel_reg == $past(wdata[0]))
    else $error("bank selector missed write");

  a_bank_reset: assert property (
    rst_evt && !rst_wdt_pd |=> bank_sel_reg == 1'b0)
    else $error("bank selector not cleared by reset");

  a_bank_wdt_hold: assert property (
    rst_evt && rst_wdt_pd |=> $stable(bank_sel_reg))
    else $error("sleep watchdog reset changed bank");

  a_bank_upper: assert property (
    rd_en && addr == `BDMA_ADDR_BANK |=> rdata[7:1] == 7'h00)
    else $error("bank selector upper bits not zero");

  a_ext_miss: assert property (
    rd_en && kind == BDMA_K_EXT && !ext_hit |=> rdata == 8'h00)
    else $error("unclaimed special location not zero");

  a_ext_bank_free: assert property (
    rd_en && ind_b && kind == BDMA_K_EXT && ext_hit
    |=> rdata == $past(ext_rdata))
    else $error("banked path lost peripheral read data");

  a_ind_ext_steer: assert property (
    wr_en && ind_b && kind == BDMA_K_EXT
    |-> ext_we && ext_addr == ptr_b_val_reg)
    else $error("indirect write not steered to pointer target");

  a_ind_self_drop: assert property (
    wr_en && (ind_a || ind_b)
    && (eff_addr == `BDMA_ADDR_IND_A || eff_addr == `BDMA_ADDR_IND_B)
    |-> kind == BDMA_K_NONE && !ext_we)
    else $error("indirect self write was not dropped");

  a_ptr_b_write: assert property (
    wr_en && addr == `BDMA_ADDR_PTR_B ##1 rd_en && addr == `BDMA_ADDR_PTR_B
    |=> rdata == $past(wdata, 2))
    else $error("pointer B did not hold written value");

  a_bank_hold: assert property (
    !rst_evt && !(wr_en && kind == BDMA_K_BANK)
    |=> $stable(bank_sel_reg))
    else $error("bank selector changed without a write");

  // Read data stands until the next read, so the core may sample it late.
  a_rdata_hold: assert property (
    !rd_en |=> $stable(rdata))
    else $error("read data changed without a read");

  c_port_b_bank1: cover property (
    wr_en && ind_b && bank_sel_reg && kind == BDMA_K_GP);
  c_wdt_hold: cover property (rst_evt && rst_wdt_pd && bank_sel_reg);
  c_ind_self: cover property (rd_en && ind_a && ptr_a_val_reg == 8'h02);
  c_ext_miss: cover property (rd_en && kind == BDMA_K_EXT && !ext_hit);
  c_ind_b_ext: cover property (
    rd_en && ind_b && bank_sel_reg && kind == BDMA_K_EXT && ext_hit);

endmodule : bdma_core

`default_nettype wire

// ===== tb/bdma_periph_model.sv
`timescale 1ns/10ps
`default_nettype none

module bdma_periph_model (
  input  wire logic       clk,        // Core clock.
  input  wire logic       ext_sel,    // Peripheral access this cycle.
  input  wire logic       ext_we,     // Peripheral write strobe.
  input  wire logic [7:0] ext_addr,   // Peripheral register address.
  input  wire logic [7:0] ext_wdata,  // Peripheral write data.
  output logic            ext_hit,    // This model owns ext_addr.
  output logic      [7:0] ext_rdata   // Read data, same cycle.
);
  logic [7:0] mem_reg [16];

  // Only 10H..1FH are claimed, so the rest of the area stays unassigned.
  assign ext_hit = ext_sel && (ext_addr[7:4] == 4'h1);

  // Without a hit the bus shows a moving pattern, never the last value.
  assign ext_rdata = ext_hit ? mem_reg[ext_addr[3:0]] : ~ext_addr;

  always_ff @(posedge clk) begin
    if (ext_we && ext_hit) begin
      mem_reg[ext_addr[3:0]] <= ext_wdata;
    end
  end
endmodule : bdma_periph_model

`default_nettype wire

// ===== tb/bdma_core_test.sv
`timescale 1ns/10ps
`default_nettype none
`include "bdma_cfg.svh"
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin \
  fail_count++; $display("FAIL t=%0t got %h exp %h", $time, g, e); end end

module bdma_core_test
  import bdma_pkg::*;
;
  logic       clk        = 1'b0;
  logic       arst_n     = 1'b0;
  logic       rst_evt    = 1'b0;
  logic       rst_wdt_pd = 1'b0;
  logic       rd_en      = 1'b0;
  logic       wr_en      = 1'b0;
  bdma_byte_t addr       = 8'h00;
  bdma_byte_t wdata      = 8'h00;
  logic [7:0] rdata;
  logic       ext_sel;
  logic       ext_we;
  logic [7:0] ext_addr;
  logic [7:0] ext_wdata;
  logic       ext_hit;
  logic [7:0] ext_rdata;
  int         fail_count  = 0;
  int         checks_done = 0;
  bdma_byte_t gp [4]      = '{8'h40, 8'h7F, 8'hA0, 8'hFF};

  always #5 clk = ~clk;

  bdma_core uut (.clk(clk), .arst_n(arst_n), .rst_evt(rst_evt),
    .rst_wdt_pd(rst_wdt_pd), .rd_en(rd_en), .wr_en(wr_en), .addr(addr),
    .wdata(wdata), .rdata(rdata), .ext_sel(ext_sel), .ext_we(ext_we),
    .ext_addr(ext_addr), .ext_wdata(ext_wdata), .ext_hit(ext_hit),
    .ext_rdata(ext_rdata));

  bdma_periph_model periph (.clk(clk), .ext_sel(ext_sel), .ext_we(ext_we),
    .ext_addr(ext_addr), .ext_wdata(ext_wdata), .ext_hit(ext_hit),
    .ext_rdata(ext_rdata));

  // Each call sets all operand inputs once and returns just after the edge.
  task automatic op(input logic r, input logic w,
                    input bdma_byte_t a, input bdma_byte_t d);
    rd_en = r;
    wr_en = w;
    addr  = a;
    wdata = d;
    @(posedge clk);
    #1;
  endtask : op

  task automatic wr(input bdma_byte_t a, input bdma_byte_t d);
    op(1'b0, 1'b1, a, d);
  endtask : wr

  task automatic rd(input bdma_byte_t a, input bdma_byte_t e);
    op(1'b1, 1'b0, a, 8'h00);
    `CHK(rdata, e)
  endtask : rd

  // A reset event, optionally with a same-cycle bank write of one.
  task automatic evt(input logic pd, input logic w);
    rst_evt    = 1'b1;
    rst_wdt_pd = pd;
    op(1'b0, w, `BDMA_ADDR_BANK, 8'h01);
    rst_evt    = 1'b0;
  endtask : evt

  task automatic summarize();
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : summarize

  initial begin
    repeat (20000) @(posedge clk);
    fail_count++;
    summarize();
  end

  initial begin
    repeat (3) @(posedge clk);
    #1;
    arst_n = 1'b1;
    rd(`BDMA_ADDR_PTR_A, 8'h00);
    rd(`BDMA_ADDR_PTR_B, 8'h00);
    rd(`BDMA_ADDR_BANK, 8'h00);
    wr(`BDMA_ADDR_BANK, 8'hFF);
    rd(`BDMA_ADDR_BANK, 8'h01);
    foreach (gp[i]) wr(gp[i], gp[i] ^ 8'hA5);
    foreach (gp[i]) rd(gp[i], gp[i] ^ 8'hA5);
    // Bank 1 is selected here; direct and port A stay in bank 0.
    wr(`BDMA_ADDR_PTR_B, 8'h40);
    wr(`BDMA_ADDR_IND_B, 8'h22);
    rd(8'h40, 8'hE5);
    rd(`BDMA_ADDR_IND_B, 8'h22);
    wr(`BDMA_ADDR_PTR_A, 8'h40);
    rd(`BDMA_ADDR_IND_A, 8'hE5);
    wr(`BDMA_ADDR_BANK, 8'h00);
    rd(`BDMA_ADDR_IND_B, 8'hE5);
    wr(`BDMA_ADDR_IND_A, 8'h33);
    rd(8'h40, 8'h33);
    wr(`BDMA_ADDR_PTR_A, 8'h00);
    wr(`BDMA_ADDR_IND_A, 8'h77);
    rd(`BDMA_ADDR_PTR_A, 8'h00);
    rd(`BDMA_ADDR_IND_A, 8'h00);
    wr(`BDMA_ADDR_PTR_B, 8'h02);
    rd(`BDMA_ADDR_IND_B, 8'h00);
    wr(`BDMA_ADDR_PTR_A, `BDMA_ADDR_PTR_B);
    rd(`BDMA_ADDR_PTR_A, `BDMA_ADDR_PTR_B);
    wr(`BDMA_ADDR_IND_A, 8'h5C);
    rd(`BDMA_ADDR_PTR_B, 8'h5C);
    wr(`BDMA_ADDR_PTR_B, 8'h4B);
    rd(`BDMA_ADDR_PTR_B, 8'h4B);
    wr(`BDMA_ADDR_BANK, 8'h01);
    wr(`BDMA_ADDR_PTR_B, `BDMA_ADDR_PTR_A);
    wr(`BDMA_ADDR_IND_B, 8'h9C);
    rd(`BDMA_ADDR_IND_B, 8'h9C);
    rd(`BDMA_ADDR_PTR_A, 8'h9C);
    wr(`BDMA_ADDR_PTR_B, 8'h12);
    wr(`BDMA_ADDR_IND_B, 8'h3C);
    rd(`BDMA_ADDR_IND_B, 8'h3C);
    wr(`BDMA_ADDR_BANK, 8'h00);
    rd(8'h12, 8'h3C);
    wr(8'h30, 8'h5A);
    rd(8'h30, 8'h00);
    wr(`BDMA_ADDR_BANK, 8'h01);
    evt(1'b1, 1'b0);
    rd(`BDMA_ADDR_BANK, 8'h01);
    evt(1'b0, 1'b1);
    rd(`BDMA_ADDR_BANK, 8'h00);
    rd(`BDMA_ADDR_PTR_A, 8'h9C);
    // A read and write of one byte in the same cycle sees the old byte.
    op(1'b1, 1'b1, 8'h7F, 8'h00);
    `CHK(rdata, 8'hDA)
    rd(8'h7F, 8'h00);
    wr(`BDMA_ADDR_BANK, 8'h01);
    arst_n = 1'b0;
    op(1'b0, 1'b0, 8'h00, 8'h00);
    arst_n = 1'b1;
    rd(`BDMA_ADDR_BANK, 8'h00);
    rd(`BDMA_ADDR_PTR_B, 8'h00);
    op(1'b0, 1'b0, 8'h00, 8'h00);
    summarize();
  end
endmodule : bdma_core_test

`default_nettype wire
